// ===== rtl/bmp_pkg.sv
// shared types and constants for the bus mode pin multiplexer
`default_nettype none
package bmp_pkg;

	typedef enum logic [1:0]
	{
		BMP_SINGLE = 2'b00,
		BMP_EXPAND = 2'b01,
		BMP_MICRO  = 2'b10
	} bmp_mode_type;

	typedef enum logic [2:0]
	{
		BMP_RGN_PERIPH   = 3'b000,
		BMP_RGN_RAM      = 3'b001,
		BMP_RGN_ROM      = 3'b010,
		BMP_RGN_VECTOR   = 3'b011,
		BMP_RGN_EXTERNAL = 3'b100,
		BMP_RGN_BLOCKED  = 3'b101,
		BMP_RGN_RESERVED = 3'b110
	} bmp_region_type;

	typedef enum logic [1:0]
	{
		BMP_ST_IDLE = 2'b00,
		BMP_ST_ADDR = 2'b01,
		BMP_ST_DATA = 2'b10,
		BMP_ST_HOLD = 2'b11
	} bmp_bus_state_type;

	typedef struct packed
	{
		logic [23:0] addr;
		logic [15:0] wdata;
		logic        write;
		logic [1:0]  lanes;
	} bmp_bus_req_type;

	localparam logic [23:0] PERIPH_LAST     = 24'h00007f;
	localparam logic [23:0] RAM_FIRST       = 24'h000080;
	localparam logic [23:0] RAM_LAST        = 24'h00087f;
	localparam logic [23:0] ROM_FIRST       = 24'h008000;
	localparam logic [23:0] ROM_SMALL_FIRST = 24'h00c000;
	localparam logic [23:0] VECTOR_FIRST    = 24'h00ffd6;
	localparam logic [23:0] ROM_LAST        = 24'h00ffff;
	localparam logic [7:0]  BANK_LIMIT      = 8'h10;
	localparam logic [23:0] CS1_FIRST       = 24'h010000;
	localparam logic [23:0] CS1_LAST        = 24'h03ffff;
	localparam logic [23:0] CS2_FIRST       = 24'h040000;
	localparam logic [23:0] CS2_LAST        = 24'h07ffff;
	localparam logic [23:0] CS3_FIRST       = 24'h080000;
	localparam logic [23:0] CS3_LAST        = 24'h0bffff;
	localparam logic [4:0]  CS_IDLE         = 5'h1f;
	localparam logic [7:0]  DIR_RESET       = 8'h00;
	localparam logic [3:0]  PHI_HALF_CYCLES = 4'h2;

	function automatic logic in_range(
		input logic [23:0] a,
		input logic [23:0] lo,
		input logic [23:0] hi
	);
		return (a >= lo) && (a <= hi);
	endfunction

endpackage
`default_nettype wire

// ===== rtl/bmp_addr_decode.sv
// bank-0 region and chip select decoder
`default_nettype none
module bmp_addr_decode (
	input  wire logic [23:0]             addr,              // address
	input  wire logic                    rom_window_select, // small rom
	input  wire bmp_pkg::bmp_mode_type   mode,              // cpu mode
	output var  bmp_pkg::bmp_region_type region,            // target
	output logic [4:0]                   cs_n               // selects
);

	logic bank0;

	assign bank0 = (addr[23:16] == 8'h00);

	always_comb
	begin
		region = bmp_pkg::BMP_RGN_RESERVED;
		cs_n = bmp_pkg::CS_IDLE;
		if (addr[23:16] >= bmp_pkg::BANK_LIMIT)
			region = bmp_pkg::BMP_RGN_BLOCKED;
		else if (bank0 && addr <= bmp_pkg::PERIPH_LAST)
			region = bmp_pkg::BMP_RGN_PERIPH;
		else if (bmp_pkg::in_range(addr, bmp_pkg::RAM_FIRST,
			bmp_pkg::RAM_LAST))
			region = bmp_pkg::BMP_RGN_RAM;
		else if (bank0 && addr >= bmp_pkg::ROM_FIRST
			&& mode != bmp_pkg::BMP_MICRO
			&& (!rom_window_select
			|| addr >= bmp_pkg::ROM_SMALL_FIRST))
		begin
			if (addr >= bmp_pkg::VECTOR_FIRST)
				region = bmp_pkg::BMP_RGN_VECTOR;
			else
				region = bmp_pkg::BMP_RGN_ROM;
		end
		else if (mode != bmp_pkg::BMP_SINGLE)
		begin
			region = bmp_pkg::BMP_RGN_EXTERNAL;
			if (bank0 && addr < bmp_pkg::ROM_FIRST)
				cs_n[0] = 1'b0;
			else if (bank0)
				cs_n[1] = 1'b0;
			else if (bmp_pkg::in_range(addr, bmp_pkg::CS1_FIRST,
				bmp_pkg::CS1_LAST))
				cs_n[1] = 1'b0;
			else if (bmp_pkg::in_range(addr, bmp_pkg::CS2_FIRST,
				bmp_pkg::CS2_LAST))
				cs_n[2] = 1'b0;
			else if (bmp_pkg::in_range(addr, bmp_pkg::CS3_FIRST,
				bmp_pkg::CS3_LAST))
				cs_n[3] = 1'b0;
			else
				cs_n[4] = 1'b0;
		end
	end

endmodule // bmp_addr_decode
`default_nettype wire

// ===== rtl/bmp_pin_mux.sv
// pin multiplexer, external bus sequencer and bank-0 routing
`default_nettype none
// Function
// - mode pin low single/expansion, high microprocessor
// - held in reset while reset pin low
// - enable pin: internal activity, else read strobe
// - width pin low 16-bit bus, high 8-bit
// - single-chip ports bidirectional, inputs after reset
// - port zero: chip selects, aux strobe, A16-A17
// - port one: high address/data, or address only
// - port two: low address multiplexed with data
// - port three: write strobes, latch, hold acknowledge
// - port four: hold, ready inputs, phase clock
// - port five also timers, key interrupts
// - port six timers, interrupts, sub-clock out
// - port seven analog, third serial, sub-oscillator
// - port eight carries first two serial channels
// - 24-bit space, banks 10 hex up blocked
// - bank-0 8000-FFFF rom outside microprocessor mode, vectors from FFD6
// - bank-0 80-87F internal ram
// - bank-0 0-7F peripheral registers
// - direct page window positioned by base register
// - window select shrinks rom to C000-FFFF
module bmp_pin_mux (
	input  wire logic                     ref_clk,              // clock
	input  wire logic                     rst,                  // reset
	input  wire logic                     reset_pin_n,          // pin
	input  wire logic                     mode_select_pin,      // pin
	input  wire logic                     byte_width_pin,       // pin
	input  wire logic                     expansion_request,    // core
	input  wire logic                     rom_window_select,    // core
	input  wire logic                     clock_out_enable,     // core
	input  wire logic                     sub_osc_enable,       // core
	input  wire logic                     sub_clock_out_enable, // core
	input  wire logic                     internal_access,      // core
	input  wire logic [15:0]              direct_page_base,     // core
	input  wire logic                     direct_page_mode,     // core
	input  wire logic [7:0]               dp_offset,            // core
	input  wire logic                     req_valid,            // request
	input  wire bmp_pkg::bmp_bus_req_type req,                  // request
	output logic                          req_ready,            // taken
	output logic                          done,                 // finished
	output logic [15:0]                   rdata,                // read data
	output var  bmp_pkg::bmp_region_type  region,               // target
	output logic                          access_fault,         // blocked
	output var  bmp_pkg::bmp_mode_type    mode,                 // cpu mode
	output logic                          device_in_reset,      // reset
	input  wire logic [8:0][7:0]          gpio_out,             // out data
	input  wire logic [8:0][7:0]          gpio_dir,             // 1=out
	output logic [8:0][7:0]               gpio_in,              // pins
	input  wire logic [3:0][7:0]          periph_sel,           // p5-p8
	input  wire logic [3:0][7:0]          periph_out,           // p5-p8
	output logic [3:0]                    key_interrupt_inputs, // p5
	output logic [2:0]                    external_interrupt_inputs, // p6
	input  wire logic [8:0][7:0]          pin_in,               // pin in
	output logic [8:0][7:0]               pin_out,              // pin out
	output logic [8:0][7:0]               pin_oe_n,             // enable
	output logic                          enable_out_n          // e pin
);

	logic [74:0]                  sync_meta;
	logic [74:0]                  sync_pins;
	logic [8:0][7:0]              pin_s;
	logic                         reset_pin_s;
	logic                         mode_pin_s;
	logic                         byte_pin_s;
	logic                         ext;
	logic                         hold_req;
	logic                         ready_in;
	logic [23:0]                  req_addr;
	logic [4:0]                   req_cs_n;
	bmp_pkg::bmp_bus_state_type   state;
	bmp_pkg::bmp_bus_state_type   next_state;
	bmp_pkg::bmp_bus_req_type     bus_req;
	bmp_pkg::bmp_bus_req_type     next_bus_req;
	bmp_pkg::bmp_mode_type        next_mode;
	logic [4:0]                   bus_cs_n;
	logic [4:0]                   next_bus_cs_n;
	logic                         next_done;
	logic [15:0]                  next_rdata;
	logic                         in_reset;
	logic                         next_in_reset;
	logic [3:0]                   phi_count;
	logic [3:0]                   next_phi_count;
	logic                         phi;
	logic                         next_phi;
	logic [8:0][7:0]              next_pin_out;
	logic [8:0][7:0]              next_pin_oe_n;
	logic                         next_enable_out_n;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sync_meta <= '0;
			sync_pins <= '0;
		end
		else
		begin
			sync_meta <= {pin_in, reset_pin_n, mode_select_pin,
				byte_width_pin};
			sync_pins <= sync_meta;
		end
	end

	assign {pin_s, reset_pin_s, mode_pin_s, byte_pin_s} = sync_pins;
	assign gpio_in = pin_s;
	assign key_interrupt_inputs = pin_s[5][7:4];
	assign external_interrupt_inputs = pin_s[6][4:2];
	assign device_in_reset = in_reset;
	assign ext = (mode != bmp_pkg::BMP_SINGLE);
	assign hold_req = ext && !pin_s[4][0];
	assign ready_in = pin_s[4][1];
	// direct page stays inside bank 0 and wraps there
	assign req_addr = direct_page_mode
		? {8'h00, direct_page_base + {8'h00, dp_offset}}
		: req.addr;

	bmp_addr_decode u_decode (
		.addr              (req_addr),
		.rom_window_select (rom_window_select),
		.mode              (mode),
		.region            (region),
		.cs_n              (req_cs_n)
	);

	assign access_fault = req_valid
		&& region == bmp_pkg::BMP_RGN_BLOCKED;
	assign req_ready = state == bmp_pkg::BMP_ST_IDLE && ext && !in_reset
		&& !hold_req && region == bmp_pkg::BMP_RGN_EXTERNAL;

	always_comb
	begin
		next_state = state;
		next_bus_req = bus_req;
		next_bus_cs_n = bus_cs_n;
		next_done = 1'b0;
		next_rdata = rdata;
		next_in_reset = !reset_pin_s;
		next_mode = mode_pin_s ? bmp_pkg::BMP_MICRO
			: (expansion_request ? bmp_pkg::BMP_EXPAND
			: bmp_pkg::BMP_SINGLE);
		next_phi_count = phi_count + 4'h1;
		next_phi = phi;
		if (phi_count == bmp_pkg::PHI_HALF_CYCLES - 4'h1)
		begin
			next_phi_count = 4'h0;
			next_phi = !phi;
		end
		case (state)
			bmp_pkg::BMP_ST_IDLE:
			begin
				if (hold_req)
					next_state = bmp_pkg::BMP_ST_HOLD;
				else if (req_valid && req_ready)
				begin
					next_state = bmp_pkg::BMP_ST_ADDR;
					next_bus_req = req;
					next_bus_req.addr = req_addr;
					next_bus_cs_n = req_cs_n;
				end
			end
			bmp_pkg::BMP_ST_ADDR:
				next_state = bmp_pkg::BMP_ST_DATA;
			bmp_pkg::BMP_ST_DATA:
			begin
				// wait extends the strobe until ready is seen high
				if (ready_in)
				begin
					next_state = bmp_pkg::BMP_ST_IDLE;
					next_done = 1'b1;
					next_bus_cs_n = bmp_pkg::CS_IDLE;
					next_rdata = byte_pin_s ? {8'h00, pin_s[2]}
						: {pin_s[1], pin_s[2]};
				end
			end
			bmp_pkg::BMP_ST_HOLD:
			begin
				if (!hold_req)
					next_state = bmp_pkg::BMP_ST_IDLE;
			end
			default:
				next_state = bmp_pkg::BMP_ST_IDLE;
		endcase
		if (in_reset)
		begin
			next_state = bmp_pkg::BMP_ST_IDLE;
			next_bus_cs_n = bmp_pkg::CS_IDLE;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= bmp_pkg::BMP_ST_IDLE;
			bus_req <= '0;
			bus_cs_n <= bmp_pkg::CS_IDLE;
			done <= 1'b0;
			rdata <= 16'h0000;
			in_reset <= 1'b1;
			mode <= bmp_pkg::BMP_SINGLE;
			phi_count <= 4'h0;
			phi <= 1'b0;
		end
		else
		begin
			state <= next_state;
			bus_req <= next_bus_req;
			bus_cs_n <= next_bus_cs_n;
			done <= next_done;
			rdata <= next_rdata;
			in_reset <= next_in_reset;
			mode <= next_mode;
			phi_count <= next_phi_count;
			phi <= next_phi;
		end
	end

	always_comb
	begin
		logic in_data;
		logic rd_cycle;
		logic wr_cycle;
		in_data = (state == bmp_pkg::BMP_ST_DATA);
		rd_cycle = in_data && !bus_req.write;
		wr_cycle = in_data && bus_req.write;
		for (int p = 0; p < 9; p++)
		begin
			next_pin_out[p] = gpio_out[p];
			next_pin_oe_n[p] = ~gpio_dir[p];
		end
		for (int q = 0; q < 4; q++)
		begin
			for (int b = 0; b < 8; b++)
			begin
				if (periph_sel[q][b])
				begin
					next_pin_out[q + 5][b] = periph_out[q][b];
					next_pin_oe_n[q + 5][b] = 1'b0;
				end
			end
		end
		if (sub_clock_out_enable)
		begin
			next_pin_out[6][7] = pin_s[7][7];
			next_pin_oe_n[6][7] = 1'b0;
		end
		if (sub_osc_enable)
		begin
			next_pin_out[7][6] = !pin_s[7][7];
			next_pin_oe_n[7][6] = 1'b0;
			next_pin_oe_n[7][7] = 1'b1;
		end
		if (ext)
		begin
			next_pin_out[0] = {bus_req.addr[17:16],
				!(state == bmp_pkg::BMP_ST_ADDR), bus_cs_n};
			next_pin_oe_n[0] = 8'h00;
			next_pin_out[1] = bus_req.addr[15:8];
			next_pin_oe_n[1] = 8'h00;
			if (!byte_pin_s && wr_cycle)
				next_pin_out[1] = bus_req.wdata[15:8];
			else if (!byte_pin_s && rd_cycle)
				next_pin_oe_n[1] = 8'hff;
			next_pin_out[2] = bus_req.addr[7:0];
			next_pin_oe_n[2] = 8'h00;
			if (wr_cycle)
				next_pin_out[2] = (byte_pin_s && bus_req.addr[0])
					? bus_req.wdata[15:8] : bus_req.wdata[7:0];
			else if (rd_cycle)
				next_pin_oe_n[2] = 8'hff;
			next_pin_out[3][3:0] = {!(state == bmp_pkg::BMP_ST_HOLD),
				state == bmp_pkg::BMP_ST_ADDR,
				!(wr_cycle && !byte_pin_s && bus_req.lanes[1]),
				!(wr_cycle && (byte_pin_s || bus_req.lanes[0]))};
			next_pin_oe_n[3][3:0] = 4'h0;
			next_pin_oe_n[4][1:0] = 2'b11;
			if (mode == bmp_pkg::BMP_MICRO || clock_out_enable)
			begin
				next_pin_out[4][2] = phi;
				next_pin_oe_n[4][2] = 1'b0;
			end
			if (state == bmp_pkg::BMP_ST_HOLD)
			begin
				next_pin_oe_n[0] = 8'hff;
				next_pin_oe_n[1] = 8'hff;
				next_pin_oe_n[2] = 8'hff;
				next_pin_oe_n[3][2:0] = 3'b111;
			end
		end
		next_pin_out[3][7:4] = 4'h0;
		next_pin_oe_n[3][7:4] = 4'hf;
		next_enable_out_n = ext ? !rd_cycle : !internal_access;
		if (in_reset)
		begin
			next_pin_oe_n = '1;
			next_enable_out_n = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_out <= '0;
			pin_oe_n <= '1;
			enable_out_n <= 1'b1;
		end
		else
		begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			enable_out_n <= next_enable_out_n;
		end
	end

	reset_float_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		in_reset |=> (pin_oe_n == '1) && enable_out_n
	) else $error("pins driven during reset");

	mode_pin_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		mode_pin_s |=> mode == bmp_pkg::BMP_MICRO
	) else $error("mode pin high without microprocessor mode");

	enable_pin_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!in_reset && mode == bmp_pkg::BMP_SINGLE
		|=> enable_out_n == !$past(internal_access)
	) else $error("enable pin does not follow internal access");

	latch_phase_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		state == bmp_pkg::BMP_ST_ADDR && !in_reset
		|=> pin_out[3][2] && !pin_oe_n[3][2] && pin_out[3][1:0] == 2'b11
	) else $error("latch enable wrong in address phase");

	low_addr_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		state == bmp_pkg::BMP_ST_ADDR && !in_reset
		|=> pin_out[2] == $past(bus_req.addr[7:0]) && pin_oe_n[2] == 8'h00
	) else $error("low address missing on port two");

	byte_high_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		state == bmp_pkg::BMP_ST_DATA && byte_pin_s && ext && !in_reset
		|=> pin_out[1] == $past(bus_req.addr[15:8])
	) else $error("8-bit bus lost high address");

	one_select_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		state == bmp_pkg::BMP_ST_ADDR && !in_reset
		|=> $countones(~pin_out[0][4:0]) == 1 ##1 pin_out[0][5]
	) else $error("chip select not unique in external cycle");

	wait_hold_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		state == bmp_pkg::BMP_ST_DATA && !ready_in && !in_reset
		|=> state == bmp_pkg::BMP_ST_DATA && !done
	) else $error("data phase ended without ready");

	bank_block_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!direct_page_mode && req.addr[23:16] >= bmp_pkg::BANK_LIMIT
		|-> region == bmp_pkg::BMP_RGN_BLOCKED && !req_ready
	) else $error("high bank reachable");

	rom_window_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!direct_page_mode && rom_window_select
		&& req.addr >= bmp_pkg::ROM_FIRST
		&& req.addr < bmp_pkg::ROM_SMALL_FIRST
		|-> region != bmp_pkg::BMP_RGN_ROM
	) else $error("rom window select ignored");

	vector_area_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!direct_page_mode && mode != bmp_pkg::BMP_MICRO
		&& bmp_pkg::in_range(req.addr, bmp_pkg::VECTOR_FIRST,
		bmp_pkg::ROM_LAST)
		|-> region == bmp_pkg::BMP_RGN_VECTOR
	) else $error("vector area not decoded");

	ram_area_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!direct_page_mode && bmp_pkg::in_range(req.addr,
		bmp_pkg::RAM_FIRST, bmp_pkg::RAM_LAST)
		|-> region == bmp_pkg::BMP_RGN_RAM
	) else $error("ram area not decoded");

	periph_area_a: assert property (
		@(posedge ref_clk) disable iff (rst)
		!direct_page_mode && req.addr <= bmp_pkg::PERIPH_LAST
		|-> region == bmp_pkg::BMP_RGN_PERIPH
	) else $error("register area not decoded");

endmodule // bmp_pin_mux
`default_nettype wire

// ===== sim/bmp_ext_mem.sv
// behavioural external memory on the expansion bus
`default_nettype none
module bmp_ext_mem (
	input  wire logic            ref_clk,      // clock
	input  wire logic            byte_mode,    // 8-bit bus
	input  wire logic [3:0]      stall,        // ready low cycles
	input  wire logic [8:0][7:0] pin_out,      // device pins
	input  wire logic            enable_out_n, // read strobe
	output logic      [15:0]     data_drv,     // p1/p2 levels
	output logic                 ready,        // ready pin
	output logic      [23:0]     last_addr,    // latched address
	output logic      [4:0]      last_cs       // selects at latch
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [256];
	logic [3:0]  wait_cnt = 4'h0;
	logic [15:0] last_drv = 16'h0000;
	logic        sel;
	logic [7:0]  lo_idx;
	assign sel = ~&pin_out[0][4:0];
	assign lo_idx = byte_mode ? last_addr[7:0] : {last_addr[7:1], 1'b0};
	// ready answers only a selected cycle, so no stale high leaks over
	assign ready = sel && wait_cnt == 4'h0;
	always_comb
	begin
		if (sel && !enable_out_n)
			data_drv = {mem[lo_idx | 8'h01], mem[lo_idx]};
		else
			data_drv = ~last_drv;
	end
	always_ff @(posedge ref_clk)
	begin
		if (!sel)
			wait_cnt <= stall;
		else if (wait_cnt != 4'h0)
			wait_cnt <= wait_cnt - 4'h1;
		if (pin_out[3][2])
		begin
			last_addr <= {6'h00, pin_out[0][7:6], pin_out[1], pin_out[2]};
			last_cs <= pin_out[0][4:0];
		end
		if (sel && !pin_out[3][0])
			mem[lo_idx] <= pin_out[2];
		if (sel && !pin_out[3][1] && !byte_mode)
			mem[lo_idx | 8'h01] <= pin_out[1];
		if (sel && !enable_out_n)
			last_drv <= data_drv;
	end
endmodule // bmp_ext_mem
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the bus mode pin multiplexer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed
	{
		logic [1:0]              mp;
		logic                    rws;
		logic [23:0]             addr;
		bmp_pkg::bmp_region_type rgn;
	} bmp_row_type;
	localparam bmp_row_type ROWS [17] = '{
		'{2'h1, 1'b0, 24'h000000, bmp_pkg::BMP_RGN_PERIPH},
		'{2'h1, 1'b0, 24'h00007f, bmp_pkg::BMP_RGN_PERIPH},
		'{2'h1, 1'b0, 24'h000080, bmp_pkg::BMP_RGN_RAM},
		'{2'h1, 1'b0, 24'h00087f, bmp_pkg::BMP_RGN_RAM},
		'{2'h1, 1'b0, 24'h000880, bmp_pkg::BMP_RGN_EXTERNAL},
		'{2'h1, 1'b0, 24'h008000, bmp_pkg::BMP_RGN_ROM},
		'{2'h1, 1'b1, 24'h008000, bmp_pkg::BMP_RGN_EXTERNAL},
		'{2'h1, 1'b1, 24'h00c000, bmp_pkg::BMP_RGN_ROM},
		'{2'h1, 1'b0, 24'h00ffd5, bmp_pkg::BMP_RGN_ROM},
		'{2'h1, 1'b0, 24'h00ffd6, bmp_pkg::BMP_RGN_VECTOR},
		'{2'h1, 1'b0, 24'h0fffff, bmp_pkg::BMP_RGN_EXTERNAL},
		'{2'h1, 1'b0, 24'h100000, bmp_pkg::BMP_RGN_BLOCKED},
		'{2'h1, 1'b0, 24'hff0000, bmp_pkg::BMP_RGN_BLOCKED},
		'{2'h0, 1'b0, 24'h000880, bmp_pkg::BMP_RGN_RESERVED},
		'{2'h0, 1'b0, 24'h00ffff, bmp_pkg::BMP_RGN_VECTOR},
		'{2'h2, 1'b0, 24'h008000, bmp_pkg::BMP_RGN_EXTERNAL},
		'{2'h2, 1'b0, 24'h000080, bmp_pkg::BMP_RGN_RAM}};
	logic ref_clk, rst, reset_pin_n, mode_select_pin, byte_width_pin;
	logic expansion_request, rom_window_select, clock_out_enable;
	logic sub_osc_enable, sub_clock_out_enable, internal_access;
	logic direct_page_mode, req_valid, req_ready, done, access_fault;
	logic device_in_reset, enable_out_n, hold_n, ready, prev;
	logic [15:0] direct_page_base, rdata, data_drv, rd;
	logic [7:0] dp_offset;
	logic [3:0] stall, key_interrupt_inputs;
	logic [2:0] external_interrupt_inputs;
	logic [23:0] last_addr;
	logic [4:0] last_cs;
	bmp_pkg::bmp_bus_req_type req;
	bmp_pkg::bmp_region_type region;
	bmp_pkg::bmp_mode_type mode;
	logic [8:0][7:0] gpio_out, gpio_dir, gpio_in, pin_in, pin_out, pin_oe_n;
	logic [8:0][7:0] ext_pins, ext;
	logic [3:0][7:0] periph_sel, periph_out;
	int miscompares, tests_run, cycles, n;

	bmp_pin_mux u_bmp_pin_mux (.ref_clk, .rst, .reset_pin_n, .mode_select_pin,
		.byte_width_pin, .expansion_request, .rom_window_select,
		.clock_out_enable, .sub_osc_enable, .sub_clock_out_enable,
		.internal_access, .direct_page_base, .direct_page_mode, .dp_offset,
		.req_valid, .req, .req_ready, .done, .rdata, .region, .access_fault,
		.mode, .device_in_reset, .gpio_out, .gpio_dir, .gpio_in, .periph_sel,
		.periph_out, .key_interrupt_inputs, .external_interrupt_inputs,
		.pin_in, .pin_out, .pin_oe_n, .enable_out_n);
	// released device pins read as pulled high at the memory
	bmp_ext_mem u_bmp_ext_mem (.ref_clk, .byte_mode(byte_width_pin), .stall,
		.pin_out(pin_out | pin_oe_n), .enable_out_n, .data_drv, .ready,
		.last_addr, .last_cs);

	// wire level from the device's pin enables, else the external level
	always_comb
	begin
		ext = ext_pins;
		ext[1] = data_drv[15:8];
		ext[2] = data_drv[7:0];
		ext[4][0] = hold_n;
		ext[4][1] = ready;
		pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
	end

	task automatic chk(input string what, input logic [23:0] exp,
		input logic [23:0] got);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge ref_clk);
	endtask

	// one request, held until taken, then wait for done
	task automatic bus(input logic [23:0] a, input logic [15:0] wd,
		input logic wr, input logic [1:0] ln, output logic [15:0] q);
		int k;
		k = 0;
		req = '{addr: a, wdata: wd, write: wr, lanes: ln};
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && k < 50)
		begin
			k++;
			tick(1);
		end
		tick(1);
		req_valid = 1'b0;
		while (done !== 1'b1 && k < 100)
		begin
			k++;
			tick(1);
		end
		q = rdata;
		chk("bus done", 1'b1, done);
		// synced ready must fall before the next data phase
		tick(3);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	initial
	begin
		{rst, reset_pin_n, hold_n} = 3'b111;
		{mode_select_pin, byte_width_pin, expansion_request} = 3'b000;
		{rom_window_select, clock_out_enable, sub_osc_enable} = 3'b000;
		{sub_clock_out_enable, internal_access, direct_page_mode} = 3'b000;
		{direct_page_base, dp_offset, stall, req_valid} = '0;
		{miscompares, tests_run, cycles} = '0;
		req = '0;
		{gpio_out, ext_pins, periph_sel, periph_out} = '0;
		gpio_dir = '1;
		tick(8);
		chk("reset float", 1'b1, &pin_oe_n);
		rst = 1'b0;
		tick(6);
		chk("in reset", 1'b0, device_in_reset);
		gpio_dir = '0;
		gpio_out[0] = 8'hff;
		gpio_dir[5] = 8'h0f;
		gpio_out[5] = 8'h5a;
		ext_pins[5] = 8'h30;
		ext_pins[6] = 8'h14;
		ext_pins[7] = 8'h80;
		sub_clock_out_enable = 1'b1;
		sub_osc_enable = 1'b1;
		periph_sel[3] = 8'h0f;
		periph_out[3] = 8'h05;
		internal_access = 1'b1;
		tick(5);
		chk("port5 oe", 8'hf0, pin_oe_n[5]);
		chk("port5 in", 8'h3a, gpio_in[5]);
		chk("key inputs", 4'h3, key_interrupt_inputs);
		chk("ext ints", 3'h5, external_interrupt_inputs);
		chk("sub clock", 1'b1, pin_out[6][7]);
		chk("sub osc", 2'b00, {pin_out[7][6], pin_oe_n[7][6]});
		chk("port8 periph", 4'h5, pin_out[8][3:0]);
		chk("e pin", 1'b0, enable_out_n);
		{gpio_out, periph_sel, sub_clock_out_enable, sub_osc_enable,
			internal_access} = '0;
		foreach (ROWS[i])
		begin
			{mode_select_pin, expansion_request} = ROWS[i].mp;
			rom_window_select = ROWS[i].rws;
			req.addr = ROWS[i].addr;
			tick(5);
			chk("region", ROWS[i].rgn, region);
			chk("mode", ROWS[i].mp[1] ? 2'h2 : {1'b0, ROWS[i].mp[0]}, mode);
		end
		{mode_select_pin, expansion_request, rom_window_select} = 3'b010;
		direct_page_mode = 1'b1;
		stall = 4'h3;
		direct_page_base = 16'hfff0;
		dp_offset = 8'h20;
		tick(1);
		chk("dp wrap", bmp_pkg::BMP_RGN_PERIPH, region);
		direct_page_base = 16'h0070;
		tick(1);
		chk("dp ram", bmp_pkg::BMP_RGN_RAM, region);
		direct_page_mode = 1'b0;
		tick(2);
		bus(24'h010004, 16'ha5c3, 1'b1, 2'b11, rd);
		chk("latched addr", 24'h010004, last_addr);
		chk("latched cs", 5'h1d, last_cs);
		bus(24'h010004, 16'h0000, 1'b0, 2'b11, rd);
		chk("read 16", 16'ha5c3, rd);
		byte_width_pin = 1'b1;
		tick(5);
		bus(24'h010005, 16'h0000, 1'b0, 2'b01, rd);
		chk("read 8", 16'h00a5, rd);
		bus(24'h010107, 16'h3c00, 1'b1, 2'b01, rd);
		chk("addr 8", 24'h010107, last_addr);
		bus(24'h010107, 16'h0000, 1'b0, 2'b01, rd);
		chk("byte write", 16'h003c, rd);
		{byte_width_pin, stall} = '0;
		hold_n = 1'b0;
		tick(6);
		chk("hold ack", 1'b0, pin_out[3][3]);
		chk("hold float", 24'hffffff, pin_oe_n[2:0]);
		hold_n = 1'b1;
		mode_select_pin = 1'b1;
		tick(6);
		n = 0;
		repeat (8)
		begin
			prev = pin_out[4][2];
			tick(1);
			n += (!prev && pin_out[4][2]);
		end
		chk("phase clock", 24'h2, n);
		bus(24'h008000, 16'h0000, 1'b0, 2'b11, rd);
		chk("micro cs", 5'h1d, last_cs);
		req.addr = 24'h100000;
		req_valid = 1'b1;
		#1;
		chk("fault", 2'b10, {access_fault, req_ready});
		tick(1);
		req_valid = 1'b0;
		reset_pin_n = 1'b0;
		tick(5);
		chk("pin reset", 2'b11, {device_in_reset, &pin_oe_n});
		reset_pin_n = 1'b1;
		tick(6);
		chk("pin release", 1'b0, device_in_reset);
		end_of_test();
	end
endmodule // tb
`default_nettype wire
